// ---- src/pfm_top.sv ----
// Pad function mux with predefined at-reset and after-reset pad settings.
// Summary of operation
// - Each pad connects to one of three functions by its select, or to none on select 3.
// - One function path goes through the routing matrix, adding latency.
// - Serial, debug, flash, fast SPI and SDIO signals route directly.
// - Flash and fast SPI groups support single, dual and quad line modes.
// - In default boot mode each pad comes up on its default function.
// - Separate input enable and pull settings apply during and after reset.
// - Drive strength resets to 20 mA, except 40 mA on both USB pads.
// - USB pads take pull-up from USB pull-up bits, strength from pull value.
// - USB disabled: USB pads are plain pads; second pad pull-up on after reset.
// - Software sets each pad's weak pull-up and pull-down independently.
// - Test clock pad after reset: input plus pull-up if fuse 0, input if 1.
// - A deselected direct input function sees its constant tie value.
`include "pfm_map.svh"
`default_nettype none
module pfm_top #(
  parameter int PAD_COUNT = `PFM_PAD_COUNT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pad side
  input wire logic [PAD_COUNT-1:0] pad_in,
  output logic [PAD_COUNT-1:0] pad_out,
  output logic [PAD_COUNT-1:0] pad_oe,
  output logic [PAD_COUNT-1:0] pad_input_enable,
  output logic [PAD_COUNT-1:0] weak_pullup_enable,
  output logic [PAD_COUNT-1:0] weak_pulldown_enable,
  output logic [2*PAD_COUNT-1:0] pad_drive,
  // USB pad pull-up
  input wire logic usb_enable,
  input wire logic [1:0] usb_line_pullup_ctrl,
  input wire logic usb_pullup_value,
  output logic [1:0] usb_pullup_enable,
  output logic usb_pullup_strength,
  // Fuse
  input wire logic pad_debug_disable_fuse,
  // Direct peripheral functions (function 0)
  input wire logic [PAD_COUNT-1:0] direct0_out,
  input wire logic [PAD_COUNT-1:0] direct0_oe,
  output logic [PAD_COUNT-1:0] direct0_in,
  // Routing matrix functions (function 1)
  input wire logic [PAD_COUNT-1:0] matrix_out,
  input wire logic [PAD_COUNT-1:0] matrix_oe,
  output logic [PAD_COUNT-1:0] matrix_in,
  // Direct peripheral functions (function 2)
  input wire logic [PAD_COUNT-1:0] direct2_out,
  input wire logic [PAD_COUNT-1:0] direct2_oe,
  output logic [PAD_COUNT-1:0] direct2_in,
  // Configuration write port
  input wire logic cfg_wr_en,
  input wire logic [4:0] cfg_wr_pad,
  input wire logic cfg_wr_func_en,
  input wire logic [1:0] cfg_wr_func,
  input wire logic cfg_wr_pad_en,
  input wire pfm_pkg::pfm_pad_cfg_t cfg_wr_cfg,
  // Configuration read port
  input wire logic [4:0] cfg_rd_pad,
  output logic [1:0] cfg_rd_func,
  output pfm_pkg::pfm_pad_cfg_t cfg_rd_cfg
);

  if (PAD_COUNT != `PFM_PAD_COUNT)
  begin : g_check
    $error("pfm_top: reset tables cover exactly the documented pad count");
  end

  pfm_pad_if #(.PAD_COUNT(PAD_COUNT)) pads ();

  pfm_pkg::pfm_func_t func_sel [PAD_COUNT];
  pfm_pkg::pfm_pad_cfg_t pad_cfg [PAD_COUNT];
  logic [PAD_COUNT-1:0] sw_written;
  logic [PAD_COUNT-1:0] matrix_out_q;
  logic [PAD_COUNT-1:0] matrix_oe_q;
  logic [PAD_COUNT-1:0] next_ie;
  logic [PAD_COUNT-1:0] next_wpu;
  logic [PAD_COUNT-1:0] next_wpd;
  logic [PAD_COUNT-1:0] dflt_wpu;
  logic wr_hit;

  localparam logic [PAD_COUNT-1:0] AFTER_IE = `PFM_AFTER_RESET_IE;
  localparam logic [PAD_COUNT-1:0] AFTER_WPD = `PFM_AFTER_RESET_WPD;

  assign wr_hit = cfg_wr_en && (32'(cfg_wr_pad) < PAD_COUNT);

  // Function selects come up on the default set and hold until written.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < PAD_COUNT; i++)
      begin
        func_sel[i] <= pfm_pkg::pfm_func_t'(`PFM_FUNC_RESET);
      end
    end
    else if (wr_hit && cfg_wr_func_en)
    begin
      func_sel[cfg_wr_pad] <= pfm_pkg::pfm_func_t'(cfg_wr_func);
    end
  end

  // Pad settings; drive strength has no separate during-reset value.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sw_written <= '0;
      for (int i = 0; i < PAD_COUNT; i++)
      begin
        pad_cfg[i] <= '0;
        if (i == `PFM_PAD_USB_DM || i == `PFM_PAD_USB_DP)
        begin
          pad_cfg[i].drive <= `PFM_DRV_40MA;
        end
        else
        begin
          pad_cfg[i].drive <= `PFM_DRV_20MA;
        end
      end
    end
    else if (wr_hit && cfg_wr_pad_en)
    begin
      pad_cfg[cfg_wr_pad] <= cfg_wr_cfg;
      sw_written[cfg_wr_pad] <= 1'b1;
    end
  end

  // After-reset defaults follow the fuse and the USB enable live until software writes.
  always_comb
  begin
    dflt_wpu = `PFM_AFTER_RESET_WPU;
    if (pad_debug_disable_fuse)
    begin
      dflt_wpu[`PFM_PAD_TEST_CLOCK] = 1'b0;
    end
    dflt_wpu[`PFM_PAD_USB_DP] = !usb_enable;
    if (usb_enable)
    begin
      dflt_wpu[`PFM_PAD_USB_DM] = 1'b0;
    end
    for (int i = 0; i < PAD_COUNT; i++)
    begin
      if (sw_written[i])
      begin
        next_ie[i] = pad_cfg[i].pad_input_enable;
        next_wpu[i] = pad_cfg[i].weak_pullup_enable;
        next_wpd[i] = pad_cfg[i].weak_pulldown_enable;
      end
      else
      begin
        next_ie[i] = AFTER_IE[i];
        next_wpu[i] = dflt_wpu[i];
        next_wpd[i] = AFTER_WPD[i];
      end
    end
  end

  // Pad settings outputs show the during-reset set while reset is held.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pad_input_enable <= `PFM_AT_RESET_IE;
      weak_pullup_enable <= `PFM_AT_RESET_WPU;
      weak_pulldown_enable <= `PFM_AT_RESET_WPD;
    end
    else
    begin
      pad_input_enable <= next_ie;
      weak_pullup_enable <= next_wpu;
      weak_pulldown_enable <= next_wpd;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < PAD_COUNT; i++)
    begin
      pad_drive[2*i +: 2] <= pad_cfg[i].drive;
    end
  end

  // USB pull-up belongs to the USB controller bits whenever USB is enabled.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      usb_pullup_enable <= `PFM_AT_RESET_USB_PULLUP;
      usb_pullup_strength <= 1'b0;
    end
    else
    begin
      usb_pullup_enable <= usb_enable ? usb_line_pullup_ctrl : 2'h0;
      usb_pullup_strength <= usb_pullup_value;
    end
  end

  // The matrix path is retimed once; it buys routing freedom at one cycle of latency.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      matrix_out_q <= '0;
      matrix_oe_q <= '0;
    end
    else
    begin
      matrix_out_q <= matrix_out;
      matrix_oe_q <= matrix_oe;
    end
  end

  always_comb
  begin
    for (int i = 0; i < PAD_COUNT; i++)
    begin
      pads.pad_function_select[i] = func_sel[i];
    end
  end

  // Per-line output enables let each SPI data pad turn around on its own.
  assign pads.fn0_out = direct0_out;
  assign pads.fn0_oe = direct0_oe;
  assign pads.fn1_out = matrix_out_q;
  assign pads.fn1_oe = matrix_oe_q;
  assign pads.fn2_out = direct2_out;
  assign pads.fn2_oe = direct2_oe;
  assign pads.pad_in = pad_in;

  pfm_pad_mux #(
    .PAD_COUNT(PAD_COUNT),
    .TIE_HIGH_FN0(`PFM_TIE_HIGH_FN0),
    .TIE_HIGH_FN2(`PFM_TIE_HIGH_FN2)
  ) u_mux (
    .pads(pads.mux)
  );

  // Registered pad and function outputs; inputs tie off while reset is held.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      direct0_in <= `PFM_TIE_HIGH_FN0;
      matrix_in <= '0;
      direct2_in <= `PFM_TIE_HIGH_FN2;
    end
    else
    begin
      pad_out <= pads.mux_out;
      pad_oe <= pads.mux_oe;
      direct0_in <= pads.fn0_in;
      matrix_in <= pads.fn1_in;
      direct2_in <= pads.fn2_in;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cfg_rd_func <= 2'h0;
      cfg_rd_cfg <= '0;
    end
    else if (32'(cfg_rd_pad) < PAD_COUNT)
    begin
      cfg_rd_func <= func_sel[cfg_rd_pad];
      cfg_rd_cfg <= pad_cfg[cfg_rd_pad];
    end
    else
    begin
      cfg_rd_func <= 2'h0;
      cfg_rd_cfg <= '0;
    end
  end

endmodule : pfm_top
`default_nettype wire

// ---- src/pfm_map.svh ----
// Constant map for the pad function mux: pad indices, reset settings and codes.
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

`define PFM_PAD_COUNT 30
`define PFM_PAD_TEST_CLOCK 6
`define PFM_PAD_USB_DM 12
`define PFM_PAD_USB_DP 13

// Pad index order: GPIO0..GPIO13, GPIO15, GPIO16..GPIO23, GPIO24..GPIO30.
`define PFM_AT_RESET_IE 30'h0000_433C
`define PFM_AT_RESET_WPU 30'h3BFE_0200
`define PFM_AT_RESET_WPD 30'h0000_0000
`define PFM_AFTER_RESET_IE 30'h3BFF_7FFC
`define PFM_AFTER_RESET_WPU 30'h3B81_8240
`define PFM_AFTER_RESET_WPD 30'h0000_0000
`define PFM_AT_RESET_USB_PULLUP 2'h2

`define PFM_TIE_HIGH_FN0 30'h2B7F_0070
`define PFM_TIE_HIGH_FN2 30'h0000_80F4

`define PFM_DRV_20MA 2'h2
`define PFM_DRV_40MA 2'h3
`define PFM_FUNC_RESET 2'h0

`endif

// ---- src/pfm_pkg.sv ----
// Types shared by the pad function mux modules.
`default_nettype none
package pfm_pkg;

  typedef enum logic [1:0] {
    PFM_FN0,
    PFM_FN1,
    PFM_FN2
  } pfm_func_t;

  typedef struct packed {
    logic pad_input_enable;
    logic weak_pullup_enable;
    logic weak_pulldown_enable;
    logic [1:0] drive;
  } pfm_pad_cfg_t;

endpackage : pfm_pkg
`default_nettype wire

// ---- src/pfm_pad_if.sv ----
// Carrier between the pad mux top and the per-pad selection logic.
`default_nettype none
interface pfm_pad_if #(
  parameter int PAD_COUNT = 30
);
  pfm_pkg::pfm_func_t pad_function_select [PAD_COUNT];
  logic [PAD_COUNT-1:0] fn0_out;
  logic [PAD_COUNT-1:0] fn0_oe;
  logic [PAD_COUNT-1:0] fn1_out;
  logic [PAD_COUNT-1:0] fn1_oe;
  logic [PAD_COUNT-1:0] fn2_out;
  logic [PAD_COUNT-1:0] fn2_oe;
  logic [PAD_COUNT-1:0] pad_in;
  logic [PAD_COUNT-1:0] mux_out;
  logic [PAD_COUNT-1:0] mux_oe;
  logic [PAD_COUNT-1:0] fn0_in;
  logic [PAD_COUNT-1:0] fn1_in;
  logic [PAD_COUNT-1:0] fn2_in;

  modport mux (
    input pad_function_select, fn0_out, fn0_oe, fn1_out, fn1_oe, fn2_out, fn2_oe, pad_in,
    output mux_out, mux_oe, fn0_in, fn1_in, fn2_in
  );
  modport top (
    output pad_function_select, fn0_out, fn0_oe, fn1_out, fn1_oe, fn2_out, fn2_oe, pad_in,
    input mux_out, mux_oe, fn0_in, fn1_in, fn2_in
  );
endinterface : pfm_pad_if
`default_nettype wire

// ---- src/pfm_pad_mux.sv ----
// Per-pad three-way function selection with idle input ties.
`default_nettype none
module pfm_pad_mux #(
  parameter int PAD_COUNT = 30,
  parameter logic [PAD_COUNT-1:0] TIE_HIGH_FN0 = '0,
  parameter logic [PAD_COUNT-1:0] TIE_HIGH_FN2 = '0
) (
  // Pad and function signals
  pfm_pad_if.mux pads
);

  for (genvar i = 0; i < PAD_COUNT; i++)
  begin : g_pad
    always_comb
    begin
      pads.fn0_in[i] = TIE_HIGH_FN0[i];
      pads.fn1_in[i] = 1'b0;
      pads.fn2_in[i] = TIE_HIGH_FN2[i];
      unique case (pads.pad_function_select[i])
        pfm_pkg::PFM_FN0:
        begin
          pads.mux_out[i] = pads.fn0_out[i];
          pads.mux_oe[i] = pads.fn0_oe[i];
          pads.fn0_in[i] = pads.pad_in[i];
        end
        pfm_pkg::PFM_FN1:
        begin
          pads.mux_out[i] = pads.fn1_out[i];
          pads.mux_oe[i] = pads.fn1_oe[i];
          pads.fn1_in[i] = pads.pad_in[i];
        end
        pfm_pkg::PFM_FN2:
        begin
          pads.mux_out[i] = pads.fn2_out[i];
          pads.mux_oe[i] = pads.fn2_oe[i];
          pads.fn2_in[i] = pads.pad_in[i];
        end
        default:
        begin
          // An illegal select parks the pad undriven rather than guessing a function.
          pads.mux_out[i] = 1'b0;
          pads.mux_oe[i] = 1'b0;
        end
      endcase
    end
  end

endmodule : pfm_pad_mux
`default_nettype wire

// ---- verif/pfm_monitor.sv ----
// Assertion checker for the pad function mux top.
`include "pfm_map.svh"
`default_nettype none
module pfm_monitor #(
  parameter int PAD_COUNT = 30
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pad settings
  input wire logic [PAD_COUNT-1:0] pad_input_enable,
  input wire logic [PAD_COUNT-1:0] weak_pullup_enable,
  input wire logic [PAD_COUNT-1:0] weak_pulldown_enable,
  input wire logic [2*PAD_COUNT-1:0] pad_drive,
  // USB and fuse
  input wire logic usb_enable,
  input wire logic [1:0] usb_line_pullup_ctrl,
  input wire logic usb_pullup_value,
  input wire logic [1:0] usb_pullup_enable,
  input wire logic usb_pullup_strength,
  input wire logic pad_debug_disable_fuse,
  // Write port
  input wire logic cfg_wr_en,
  input wire logic [4:0] cfg_wr_pad,
  input wire logic cfg_wr_pad_en,
  input wire pfm_pkg::pfm_pad_cfg_t cfg_wr_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_rst_set;
    disable iff (1'b0) reset |=> pad_input_enable == `PFM_AT_RESET_IE
      && weak_pullup_enable == `PFM_AT_RESET_WPU;
  endproperty
  a_rst_set: assert property (p_rst_set) else $error("reset pad set wrong");
  property p_rst_usb;
    disable iff (1'b0) reset |=> usb_pullup_enable == `PFM_AT_RESET_USB_PULLUP;
  endproperty
  a_rst_usb: assert property (p_rst_usb) else $error("reset usb pull-up wrong");
  property p_drv;
    disable iff (1'b0) reset ##1 reset |=> pad_drive[27:24] == 4'hF && pad_drive[1:0] == 2'h2;
  endproperty
  a_drv: assert property (p_drv) else $error("drive default wrong");
  property p_after;
    $fell(reset) |=> pad_input_enable == `PFM_AFTER_RESET_IE && weak_pulldown_enable == '0;
  endproperty
  a_after: assert property (p_after) else $error("after reset set wrong");
  property p_tck;
    $fell(reset) |=> weak_pullup_enable[6] == !pad_debug_disable_fuse;
  endproperty
  a_tck: assert property (p_tck) else $error("test clock pull-up wrong");
  property p_usb13;
    $fell(reset) |=> weak_pullup_enable[13] == !usb_enable && !weak_pullup_enable[12];
  endproperty
  a_usb13: assert property (p_usb13) else $error("usb pad pull-up wrong");
  property p_usbpu;
    1'b1 |=> usb_pullup_strength == $past(usb_pullup_value)
      && usb_pullup_enable == ($past(usb_enable) ? $past(usb_line_pullup_ctrl) : 2'h0);
  endproperty
  a_usbpu: assert property (p_usbpu) else $error("usb pull-up control wrong");
  property p_wr;
    cfg_wr_en && cfg_wr_pad_en && cfg_wr_pad < 5'd30 |=> ##1
      {pad_input_enable[$past(cfg_wr_pad, 2)], weak_pullup_enable[$past(cfg_wr_pad, 2)],
      weak_pulldown_enable[$past(cfg_wr_pad, 2)], pad_drive[2*$past(cfg_wr_pad, 2) +: 2]}
      == $past(cfg_wr_cfg, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("pad write not applied");
  c_wr: cover property (cfg_wr_en && cfg_wr_pad_en);
  c_fuse: cover property ($fell(reset) && pad_debug_disable_fuse);
  c_usb_off: cover property ($fell(reset) && !usb_enable);
endmodule : pfm_monitor
bind pfm_top pfm_monitor #(.PAD_COUNT(PAD_COUNT)) i_pfm_monitor (
  .clk_sys(clk_sys),
  .reset(reset),
  .pad_input_enable(pad_input_enable),
  .weak_pullup_enable(weak_pullup_enable),
  .weak_pulldown_enable(weak_pulldown_enable),
  .pad_drive(pad_drive),
  .usb_enable(usb_enable),
  .usb_line_pullup_ctrl(usb_line_pullup_ctrl),
  .usb_pullup_value(usb_pullup_value),
  .usb_pullup_enable(usb_pullup_enable),
  .usb_pullup_strength(usb_pullup_strength),
  .pad_debug_disable_fuse(pad_debug_disable_fuse),
  .cfg_wr_en(cfg_wr_en),
  .cfg_wr_pad(cfg_wr_pad),
  .cfg_wr_pad_en(cfg_wr_pad_en),
  .cfg_wr_cfg(cfg_wr_cfg)
);
`default_nettype wire

// ---- verif/pfm_pad_model.sv ----
// Behavioural model of the pads and the board around them.
`default_nettype none
module pfm_pad_model (
  // Pad drive from the block
  input wire logic [29:0] pad_out,
  input wire logic [29:0] pad_oe,
  input wire logic [29:0] weak_pullup_enable,
  input wire logic [29:0] weak_pulldown_enable,
  // Outside level on undriven pads
  input wire logic [29:0] ext,
  // Level seen at the pads
  output logic [29:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pad settles to its pull, or to ext with no pull enabled, never to a stale driven value.
  assign pad_in = (pad_oe & pad_out)
    | (~pad_oe & (weak_pullup_enable | (~weak_pulldown_enable & ext)));
endmodule : pfm_pad_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the pad function mux.
`include "pfm_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, usb_enable, usb_pullup_value, usb_pullup_strength;
  logic pad_debug_disable_fuse, cfg_wr_en, cfg_wr_func_en, cfg_wr_pad_en;
  logic [1:0] usb_line_pullup_ctrl, usb_pullup_enable, cfg_wr_func, cfg_rd_func;
  logic [4:0] cfg_wr_pad, cfg_rd_pad;
  logic [29:0] pad_in, pad_out, pad_oe, pad_input_enable, weak_pullup_enable, ext;
  logic [29:0] weak_pulldown_enable, direct0_out, direct0_oe, direct0_in, matrix_out;
  logic [29:0] matrix_oe, matrix_in, direct2_out, direct2_oe, direct2_in;
  logic [59:0] pad_drive;
  pfm_pkg::pfm_pad_cfg_t cfg_wr_cfg, cfg_rd_cfg;
  int n_fail = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  pfm_top i_pfm_top (
    .clk_sys(clk_sys), .reset(reset), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_input_enable(pad_input_enable), .weak_pullup_enable(weak_pullup_enable),
    .weak_pulldown_enable(weak_pulldown_enable), .pad_drive(pad_drive),
    .usb_enable(usb_enable), .usb_line_pullup_ctrl(usb_line_pullup_ctrl),
    .usb_pullup_value(usb_pullup_value), .usb_pullup_enable(usb_pullup_enable),
    .usb_pullup_strength(usb_pullup_strength),
    .pad_debug_disable_fuse(pad_debug_disable_fuse),
    .direct0_out(direct0_out), .direct0_oe(direct0_oe), .direct0_in(direct0_in),
    .matrix_out(matrix_out), .matrix_oe(matrix_oe), .matrix_in(matrix_in),
    .direct2_out(direct2_out), .direct2_oe(direct2_oe), .direct2_in(direct2_in),
    .cfg_wr_en(cfg_wr_en), .cfg_wr_pad(cfg_wr_pad), .cfg_wr_func_en(cfg_wr_func_en),
    .cfg_wr_func(cfg_wr_func), .cfg_wr_pad_en(cfg_wr_pad_en), .cfg_wr_cfg(cfg_wr_cfg),
    .cfg_rd_pad(cfg_rd_pad), .cfg_rd_func(cfg_rd_func), .cfg_rd_cfg(cfg_rd_cfg)
  );
  pfm_pad_model i_pfm_pad_model (
    .pad_out(pad_out), .pad_oe(pad_oe), .weak_pullup_enable(weak_pullup_enable),
    .weak_pulldown_enable(weak_pulldown_enable), .ext(ext), .pad_in(pad_in)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic nw(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : nw

  task automatic wr(input logic [4:0] p, input logic [1:0] f, input logic fe, input logic pe,
    input logic [4:0] c);
    @(posedge clk_sys);
    cfg_wr_en <= 1'b1;
    cfg_wr_pad <= p;
    cfg_wr_func_en <= fe;
    cfg_wr_func <= f;
    cfg_wr_pad_en <= pe;
    cfg_wr_cfg <= c;
  endtask : wr

  task automatic idle;
    @(posedge clk_sys);
    cfg_wr_en <= 1'b0;
    nw(4);
  endtask : idle

  task automatic src(input logic [2:0] m);
    @(posedge clk_sys);
    direct0_out <= {30{m[0]}};
    matrix_out <= {30{m[1]}};
    direct2_out <= {30{m[2]}};
    nw(4);
  endtask : src

  task automatic t_reset(input logic fuse, input logic usb);
    @(posedge clk_sys);
    reset <= 1'b1;
    pad_debug_disable_fuse <= fuse;
    usb_enable <= usb;
    repeat (10) @(posedge clk_sys);
    nw(1);
    chk(pad_input_enable, `PFM_AT_RESET_IE);
    chk(weak_pullup_enable, `PFM_AT_RESET_WPU);
    chk(usb_pullup_enable, 2'h2);
    chk(pad_drive, 60'hAAA_AAAA_AFAA_AAAA);
    chk(direct0_in, `PFM_TIE_HIGH_FN0);
    @(posedge clk_sys);
    reset <= 1'b0;
    nw(2);
    chk(pad_input_enable, `PFM_AFTER_RESET_IE);
    chk(weak_pullup_enable,
      `PFM_AFTER_RESET_WPU & ~{23'h0, fuse, 6'h0} | {16'h0, ~usb, 13'h0});
    chk(weak_pulldown_enable, `PFM_AFTER_RESET_WPD);
    $display("reset test done");
  endtask : t_reset

  task automatic t_usb;
    @(posedge clk_sys);
    usb_line_pullup_ctrl <= 2'h1;
    usb_pullup_value <= 1'b1;
    nw(3);
    chk({usb_pullup_enable, usb_pullup_strength}, 3'h3);
    @(posedge clk_sys);
    usb_enable <= 1'b0;
    nw(3);
    chk({usb_pullup_enable, usb_pullup_strength}, 3'h1);
    $display("usb test done");
  endtask : t_usb

  task automatic t_cfg;
    wr(5'h05, 2'h0, 1'b0, 1'b1, 5'h16);
    wr(5'h0D, 2'h0, 1'b0, 1'b1, 5'h0A);
    wr(5'h1F, 2'h0, 1'b0, 1'b1, 5'h1F);
    idle();
    chk({pad_input_enable[5], weak_pullup_enable[5], weak_pulldown_enable[5]}, 3'h5);
    chk({pad_input_enable[13], weak_pullup_enable[13], weak_pulldown_enable[13]}, 3'h2);
    @(posedge clk_sys);
    cfg_rd_pad <= 5'h05;
    nw(2);
    chk(cfg_rd_cfg, 5'h16);
    @(posedge clk_sys);
    cfg_rd_pad <= 5'h1F;
    nw(2);
    chk(cfg_rd_cfg, 5'h00);
    $display("config test done");
  endtask : t_cfg

  task automatic t_func;
    @(posedge clk_sys);
    {direct0_oe, matrix_oe, direct2_oe} <= '1;
    cfg_rd_pad <= 5'h04;
    src(3'h1);
    chk({pad_out, pad_oe}, {60{1'b1}});
    for (int f = 0; f < 3; f++)
    begin
      wr(5'h04, f[1:0], 1'b1, 1'b0, 5'h00);
      idle();
      chk(cfg_rd_func, f[1:0]);
      src(3'h1 << f);
      chk({pad_out[4], matrix_in[4]}, {1'b1, f == 1});
      src(~(3'h1 << f));
      chk({pad_out[4], direct0_in[4], direct2_in[4]}, {1'b0, f != 0, f != 2});
    end
    wr(5'h04, 2'h3, 1'b1, 1'b0, 5'h00);
    idle();
    chk({cfg_rd_func, pad_oe[4], direct0_in[4], matrix_in[4], direct2_in[4]}, 6'h35);
    $display("function test done");
  endtask : t_func

  initial
  begin
    reset = 1'b1;
    usb_enable = 1'b1;
    {cfg_wr_en, cfg_wr_func_en, cfg_wr_pad_en, cfg_wr_func, cfg_wr_pad, cfg_rd_pad} = '0;
    {cfg_wr_cfg, usb_line_pullup_ctrl, usb_pullup_value, pad_debug_disable_fuse} = '0;
    {direct0_out, direct0_oe, matrix_out, matrix_oe, direct2_out, direct2_oe, ext} = '0;
    t_reset(1'b1, 1'b0);
    t_cfg();
    t_reset(1'b0, 1'b1);
    t_usb();
    t_func();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
